// ===== hdl/aicp_pkg.sv
// shared constants and types for the audio input capture port
package aicp_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned BUF_DEPTH = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // delay from frame-sync edge to the enable test
  localparam int unsigned CHECK_DELAY_NS = 32;
  localparam int unsigned CHECK_CYC_I =
    (CHECK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] CHECK_CYC = CHECK_CYC_I[2:0];
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 4'h1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;

  // one captured slot word with its channel tag
  typedef struct packed {
    logic right;
    logic [WORD_W-1:0] data;
  } aicp_entry_t;

  // link-side state, clocked by the bit clock
  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic fs_prev;
    aicp_entry_t hold;
    logic tgl;
  } aicp_link_st_t;

  // core-side state, clocked by i_clk
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic [2:0] cnt;
    logic [ADDR_W-1:0] ptr;
    logic wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    aicp_entry_t wr_entry;
    aicp_entry_t rd_entry;
  } aicp_core_st_t;
endpackage

// ===== hdl/aicp_capture.sv
// audio input capture port: slot shifter, edge-timed enable test, capture buffer
`timescale 1ns/100ps

// Behaviour
// - input shifter keeps shifting serial bits every bit clock, enabled or not.
// - enable is tested four core clocks after each frame-sync edge is seen.
// - enable found set at the test stores the word of the previous slot.
// - enable in early window (before the test) stores preceding channel first, else own channel first.
// - every stored word carries a left/right tag; tags alternate, and the first word is left or right as enable timing falls.
module aicp_capture (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bclk,
  input wire logic i_link_reset_n,
  input wire logic i_frame_sync_lr_clock,
  input wire logic i_sdata,
  input wire logic i_enable,
  input wire logic [aicp_pkg::ADDR_W-1:0] i_rd_addr,
  output logic o_wr_valid,
  output logic [aicp_pkg::ADDR_W-1:0] o_wr_addr,
  output aicp_pkg::aicp_entry_t o_wr_entry,
  output aicp_pkg::aicp_entry_t o_rd_entry,
  output logic o_enabled
);

  // ************************************************
  // link domain
  // ************************************************
  aicp_pkg::aicp_link_st_t lk_r;
  aicp_pkg::aicp_link_st_t lk_nxt;
  logic fs_q;
  logic sd_q;

  // pins are launched on the bit clock; one register stage aligns them
  always_ff @(posedge i_bclk) begin
    fs_q <= i_frame_sync_lr_clock;
    sd_q <= i_sdata;
  end

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.shift = {lk_r.shift[aicp_pkg::WORD_W-2:0], sd_q};
    lk_nxt.fs_prev = fs_q;
    if (fs_q != lk_r.fs_prev) begin
      // slot just ended; low frame sync means the left slot
      lk_nxt.hold.data = lk_r.shift;
      lk_nxt.hold.right = lk_r.fs_prev;
      lk_nxt.tgl = ~lk_r.tgl;
    end
  end

  always_ff @(posedge i_bclk) begin
    if (!i_link_reset_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ************************************************
  // core domain
  // ************************************************
  aicp_pkg::aicp_core_st_t cr_r;
  aicp_pkg::aicp_core_st_t cr_nxt;
  aicp_pkg::aicp_entry_t mem [aicp_pkg::BUF_DEPTH];
  logic edge_evt;
  logic check;

  // hold word stays still for a whole slot, far longer than sync plus test delay
  assign edge_evt = cr_r.tg_s2 ^ cr_r.tg_s3;
  assign check = (cr_r.cnt == aicp_pkg::CNT_ONE);

  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.en_s1 = i_enable;
    cr_nxt.en_s2 = cr_r.en_s1;
    cr_nxt.tg_s1 = lk_r.tgl;
    cr_nxt.tg_s2 = cr_r.tg_s1;
    cr_nxt.tg_s3 = cr_r.tg_s2;
    cr_nxt.wr_valid = 1'b0;
    if (edge_evt) begin
      cr_nxt.cnt = aicp_pkg::CHECK_CYC;
    end else if (cr_r.cnt != aicp_pkg::CNT_ZERO) begin
      cr_nxt.cnt = cr_r.cnt - aicp_pkg::CNT_ONE;
    end
    if (!cr_r.en_s2) begin
      // disabled: next enable restarts at the first buffer location
      cr_nxt.ptr = aicp_pkg::ADDR_ZERO;
    end else if (check) begin
      // an early enable (set before the test) lands the earlier slot first
      cr_nxt.wr_valid = 1'b1;
      cr_nxt.wr_addr = cr_r.ptr;
      cr_nxt.wr_entry = lk_r.hold;
      cr_nxt.ptr = cr_r.ptr + aicp_pkg::ADDR_ONE;
    end
    cr_nxt.rd_entry = mem[i_rd_addr];
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cr_r <= '0;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (cr_r.wr_valid) begin
      mem[cr_r.wr_addr] <= cr_r.wr_entry;
    end
  end

  assign o_wr_valid = cr_r.wr_valid;
  assign o_wr_addr = cr_r.wr_addr;
  assign o_wr_entry = cr_r.wr_entry;
  assign o_rd_entry = cr_r.rd_entry;
  assign o_enabled = cr_r.en_s2;

  // ************************************************
  // assertions
  // ************************************************
  property p_shift_moves;
    @(posedge i_bclk) disable iff (!i_link_reset_n)
      ##1 (lk_r.shift[0] == $past(sd_q)) &&
        (lk_r.shift[aicp_pkg::WORD_W-1:1] == $past(lk_r.shift[aicp_pkg::WORD_W-2:0]));
  endproperty
  a_shift_moves: assert property (p_shift_moves) else $error("shifter stalled");

  property p_fs_track;
    @(posedge i_bclk) disable iff (!i_link_reset_n)
      ##1 lk_r.fs_prev == $past(fs_q);
  endproperty
  a_fs_track: assert property (p_fs_track) else $error("frame-sync level not tracked");

  property p_hold_capture;
    @(posedge i_bclk) disable iff (!i_link_reset_n)
      (fs_q != lk_r.fs_prev) |=> (lk_r.hold.data == $past(lk_r.shift)) && (lk_r.hold.right == $past(lk_r.fs_prev));
  endproperty
  a_hold_capture: assert property (p_hold_capture) else $error("slot word not latched at frame-sync edge");

  property p_toggle_flip;
    @(posedge i_bclk) disable iff (!i_link_reset_n)
      (fs_q != lk_r.fs_prev) |=> (lk_r.tgl != $past(lk_r.tgl));
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("slot toggle did not flip");

  // hold must not move inside a slot: the core reads it without its own sync
  property p_hold_still;
    @(posedge i_bclk) disable iff (!i_link_reset_n)
      (fs_q == lk_r.fs_prev) |=> ($stable(lk_r.hold) && $stable(lk_r.tgl));
  endproperty
  a_hold_still: assert property (p_hold_still) else $error("hold word changed inside slot");

  property p_cnt_load;
    @(posedge i_clk) disable iff (!i_reset_n)
      edge_evt |=> (cr_r.cnt == aicp_pkg::CHECK_CYC);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("test delay counter not loaded");

  property p_cnt_idle;
    @(posedge i_clk) disable iff (!i_reset_n)
      ((cr_r.cnt == aicp_pkg::CNT_ZERO) && !edge_evt) |=> (cr_r.cnt == aicp_pkg::CNT_ZERO);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("test delay counter moved without edge");

  property p_wr_pulse;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_wr_valid |=> !o_wr_valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  property p_ptr_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
      !cr_r.en_s2 |=> (cr_r.ptr == aicp_pkg::ADDR_ZERO);
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared while disabled");

  property p_wr_addr_ptr;
    @(posedge i_clk) disable iff (!i_reset_n)
      (check && cr_r.en_s2) |=> (o_wr_addr == $past(cr_r.ptr));
  endproperty
  a_wr_addr_ptr: assert property (p_wr_addr_ptr) else $error("write address is not the pointer");

  property p_ptr_step;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_wr_valid |-> (cr_r.ptr == o_wr_addr + aicp_pkg::ADDR_ONE);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance after write");

  property p_check_delay;
    @(posedge i_clk) disable iff (!i_reset_n)
      edge_evt |-> !check ##1 !check ##1 !check ##1 !check ##1 check;
  endproperty
  a_check_delay: assert property (p_check_delay) else $error("enable test not four cycles after edge");

  property p_store_on_enable;
    @(posedge i_clk) disable iff (!i_reset_n)
      (check && cr_r.en_s2) |=> (o_wr_valid && o_wr_entry == $past(lk_r.hold));
  endproperty
  a_store_on_enable: assert property (p_store_on_enable) else $error("enabled test did not store word");

  property p_no_store_disabled;
    @(posedge i_clk) disable iff (!i_reset_n)
      !(check && cr_r.en_s2) |=> !o_wr_valid;
  endproperty
  a_no_store_disabled: assert property (p_no_store_disabled) else $error("word stored without enable test");

  property p_tag_alternates;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_wr_valid && o_wr_addr != aicp_pkg::ADDR_ZERO) |-> (o_wr_entry.right != mem[o_wr_addr - aicp_pkg::ADDR_ONE].right);
  endproperty
  a_tag_alternates: assert property (p_tag_alternates) else $error("channel tags do not alternate");

  property p_enable_sync;
    @(posedge i_clk) disable iff (!i_reset_n)
      ##2 o_enabled == $past(i_enable, 2);
  endproperty
  a_enable_sync: assert property (p_enable_sync) else $error("enable not two-stage synchronised");

endmodule // aicp_capture

// ===== dv/aicp_src.sv
// serial audio source model: bit clock, frame sync, msb-first slot words
`timescale 1ns/100ps
module aicp_src (
  input wire logic i_run,
  output logic o_bclk,
  output logic o_fs,
  output logic o_sdata,
  output logic [30:0] o_slot
);
  logic [4:0] bit_r;
  logic [31:0] word_r;
  // odd phase offset keeps link clock edges 1 ns off the core clock edges
  initial begin
    o_bclk = 1'b0;
    o_fs = 1'b0;
    o_sdata = 1'b0;
    o_slot = 31'h0;
    bit_r = 5'h0;
    word_r = 32'h0;
    #13;
    forever begin
      #32;
      if (i_run) o_bclk = ~o_bclk;
    end
  end
  // slot word is {fs level, slot index}; index updated before fs so watchers see it
  always @(negedge o_bclk) begin
    if (bit_r == 5'h0) begin
      o_slot = o_slot + 31'h1;
      o_fs = ~o_fs;
      word_r = {o_fs, o_slot};
    end
    o_sdata = word_r[5'h1F - bit_r];
    bit_r = bit_r + 5'h1;
  end
endmodule // aicp_src

// ===== dv/aicp_capture_bench.sv
// self-checking testbench for the audio input capture port
`timescale 1ns/100ps
module aicp_capture_bench;
  logic i_clk, i_reset_n, i_link_reset_n, i_enable, run, bclk, fs, sd, o_wr_valid, o_enabled;
  logic [3:0] i_rd_addr, o_wr_addr;
  logic [30:0] slot, idx;
  aicp_pkg::aicp_entry_t o_wr_entry, o_rd_entry;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // rows: core cycles after frame-sync edge before enable, slots back of first entry
  int rows [2][2] = '{'{3, 1}, '{25, 0}};
  aicp_src src (.i_run(run), .o_bclk(bclk), .o_fs(fs), .o_sdata(sd), .o_slot(slot));
  aicp_capture DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bclk(bclk), .i_link_reset_n(i_link_reset_n),
    .i_frame_sync_lr_clock(fs), .i_sdata(sd), .i_enable(i_enable), .i_rd_addr(i_rd_addr),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_entry(o_wr_entry), .o_rd_entry(o_rd_entry),
    .o_enabled(o_enabled));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ****
  // checking helpers
  // ****
  function automatic logic [32:0] exp_of(input logic [30:0] n);
    return {n[0], n[0], n};
  endfunction
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wait_wr;
    for (int k = 0; k < 600; k++) begin
      @(posedge i_clk);
      #1;
      if (o_wr_valid === 1'b1) break;
    end
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    {i_reset_n, i_link_reset_n, i_enable} = 3'h0;
    run = 1'b1;
    i_rd_addr = 4'h0;
    repeat (2) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    chk(33'(o_wr_valid), 33'h0);
    chk(33'(o_enabled), 33'h0);
    repeat (20) @(posedge i_clk);
    #1 i_link_reset_n = 1'b1;
    repeat (2) @(fs);
    foreach (rows[r]) begin
      @(fs);
      idx = slot - 31'(rows[r][1]);
      repeat (rows[r][0]) @(posedge i_clk);
      #1 i_enable = 1'b1;
      wait_wr;
      chk(33'(o_wr_valid), 33'h1);
      chk(o_wr_entry, exp_of(idx));
      chk(33'(o_wr_addr), 33'h0);
      chk(33'(o_enabled), 33'h1);
      wait_wr;
      chk(o_wr_entry, exp_of(idx + 31'h1));
      chk(33'(o_wr_addr), 33'h1);
      repeat (2) @(posedge i_clk);
      #1 chk(o_rd_entry, exp_of(idx));
      i_rd_addr = 4'h1;
      @(posedge i_clk);
      #1 chk(o_rd_entry, exp_of(idx + 31'h1));
      i_rd_addr = 4'h0;
      i_enable = 1'b0;
      repeat (300) @(posedge i_clk);
      #1;
    end
    wrap_up;
  end
endmodule // aicp_capture_bench
